// *** src/aop_pkg.sv ***
// Shared constants and types for the converter output path
package aop_pkg;
    localparam int DATA_W      = 10;
    localparam int LATENCY     = 9;
    localparam int BIST_CYCLES = 512;

    // Register byte addresses
    localparam logic [7:0] ADDR_CHAN_SEL = 8'h05;
    localparam logic [7:0] ADDR_POWER    = 8'h08;
    localparam logic [7:0] ADDR_TEST     = 8'h0D;
    localparam logic [7:0] ADDR_BIST     = 8'h0E;
    localparam logic [7:0] ADDR_OMODE    = 8'h14;
    localparam logic [7:0] ADDR_BIST_RES = 8'h24;

    // Reset values
    localparam logic [7:0] RST_CHAN_SEL  = 8'h03;
    localparam logic [7:0] RST_ZERO      = 8'h00;

    // Field positions
    localparam int OM_FMT_LO = 0;
    localparam int OM_DCO_INV = 2;
    localparam int OM_MUX     = 3;
    localparam int OM_DIS     = 4;
    localparam int ST_EN      = 0;
    localparam int ST_INIT    = 2;
    localparam int TM_PNL_RST = 4;
    localparam int TM_PNS_RST = 5;
    localparam int RES_PASS   = 0;
    localparam logic [7:0] TM_KEEP = 8'h0F;
    localparam logic [7:0] PWR_KEEP = 8'h03;

    // Power modes
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_STBY   = 2'h2;

    // Output encodings
    localparam logic [1:0] FMT_OFFSET = 2'h0;
    localparam logic [1:0] FMT_TWOS   = 2'h1;
    localparam logic [1:0] FMT_GRAY   = 2'h2;

    // Test pattern selections
    localparam logic [3:0] TP_OFF    = 4'h0;
    localparam logic [3:0] TP_MID    = 4'h1;
    localparam logic [3:0] TP_PFS    = 4'h2;
    localparam logic [3:0] TP_NFS    = 4'h3;
    localparam logic [3:0] TP_CHECK  = 4'h4;
    localparam logic [3:0] TP_PNL    = 4'h5;
    localparam logic [3:0] TP_PNS    = 4'h6;
    localparam logic [3:0] TP_TOGGLE = 4'h7;

    // Raw codes in offset binary
    localparam logic [DATA_W-1:0] CODE_MID = 10'h200;
    localparam logic [DATA_W-1:0] CODE_PFS = 10'h3FF;
    localparam logic [DATA_W-1:0] CODE_NFS = 10'h000;
    localparam logic [DATA_W-1:0] CODE_CHK = 10'h155;

    // Pseudorandom generators
    localparam int PNL_W = 23;
    localparam logic [22:0] PNL_TAPS = 23'h420000;
    localparam logic [22:0] PNL_SEED = 23'h7FFFFF;
    localparam int PNS_W = 9;
    localparam logic [8:0]  PNS_TAPS = 9'h110;
    localparam logic [8:0]  PNS_SEED = 9'h1FF;
    localparam int BPN_W = 16;
    localparam logic [15:0] BPN_TAPS = 16'hB400;
    localparam logic [15:0] BPN_SEED = 16'hFFFF;

    // Signature
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam int STRAP_WAIT = 3;

    typedef enum logic [2:0] {
        BIST_IDLE  = 3'b001,
        BIST_RUN   = 3'b010,
        BIST_CHECK = 3'b100
    } aop_bist_e;

    typedef struct packed {
        logic              ovr;
        logic [DATA_W-1:0] code;
    } aop_core_s;

    typedef struct packed {
        logic              raw;
        logic              ovr;
        logic [DATA_W-1:0] code;
    } aop_sample_s;

    typedef struct packed {
        logic              data_clock_out;
        logic              ovr;
        logic [DATA_W-1:0] data;
    } aop_chan_out_s;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aop_reg_req_s;
endpackage

// *** src/aop_lfsr.sv ***
// Shift-register pseudorandom source with restart
`timescale 1ns/1ps
module aop_lfsr #(
    parameter int         W    = 16,
    parameter logic [W-1:0] TAPS = '1,
    parameter logic [W-1:0] SEED = '1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         ce_in,
    input  wire logic         init_in,
    input  wire logic         step_in,
    output logic [W-1:0]      state_out
);
    logic [W-1:0] state_r;
    logic [W-1:0] state_nxt;

    // Restart beats stepping
    always_comb begin
        state_nxt = state_r;
        if (ce_in) begin
            if (init_in) begin
                state_nxt = SEED;
            end else if (step_in) begin
                state_nxt = {state_r[W-2:0], ^(state_r & TAPS)};
            end
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= SEED;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign state_out = state_r;
endmodule

// *** src/aop_top.sv ***
// Output path, test patterns and self-test of a dual converter
//
// Contract
// - Power-down by register or pin high; pin low returns to normal.
// - Power-down holds all parallel output drivers in high impedance.
// - Standby keeps the reference powered for faster wake-up.
// - Both channel results may share one output bus.
// - Strap mode: format pin low gives offset binary, high twos complement.
// - Register mode offers offset binary, twos complement or gray code.
// - Disable pin low drives data and clocks; high floats both.
// - Bit 4 of output mode floats each channel independently.
// - Result appears nine sample cycles later, updating after rising edge.
// - Two data clocks, data valid on rising edge unless inverted.
// - Zero input gives midscale code; overrange flag passes from core.
// - Self-test injects pseudorandom data into both channels, signs output.
// - Self-test runs 512 cycles, stops, then compares the signature.
// - Match sets result bit 0; mismatch clears it.
// - Outputs stay connected during self-test.
// - Writing enable and init starts self-test and restarts the source.
// - At completion the enable bit clears automatically.
// - Init written zero continues the sequence from its last value.
// - Test pattern replaces core data; only some patterns get formatted.
// - Bits 4 or 5 of test mode restart pattern generators.
// - Patterns only advance while the sample clock runs.
`timescale 1ns/1ps
module aop_top #(
    parameter int          LATENCY     = aop_pkg::LATENCY,
    parameter int          BIST_CYCLES = aop_pkg::BIST_CYCLES,
    parameter logic [15:0] BIST_SIG    = 16'h0000
) (
    input  wire logic                   clk_in,
    input  wire logic                   rst_b_in,
    input  wire logic                   ce_in,
    input  wire logic                   power_down_pin_in,
    input  wire logic                   output_disable_pin_in,
    input  wire logic                   format_strap_pin_in,
    input  wire logic                   serial_select_pin_in,
    input  wire aop_pkg::aop_core_s     core_a_in,
    input  wire aop_pkg::aop_core_s     core_b_in,
    input  wire aop_pkg::aop_reg_req_s  reg_req_in,
    output logic [7:0]                  reg_rdata_out,
    output aop_pkg::aop_chan_out_s      chan_a_out,
    output aop_pkg::aop_chan_out_s      chan_b_out,
    output logic                        chan_a_oe_out,
    output logic                        chan_b_oe_out,
    output logic                        core_power_out,
    output logic                        reference_on_out,
    output logic                        bist_busy_out
);
    localparam int CNT_W = $clog2(BIST_CYCLES);
    localparam int DW    = aop_pkg::DATA_W;

    typedef struct packed {
        logic [3:0]                      sync1;
        logic [3:0]                      sync2;
        logic                            phase;
        logic                            alt;
        logic [1:0]                      strap_cnt;
        logic                            strap_twos;
        logic [7:0]                      chan_sel;
        logic [7:0]                      power_mode;
        logic [7:0]                      output_test_mode;
        logic [7:0]                      selftest_control;
        logic [7:0]                      output_mode_a;
        logic [7:0]                      output_mode_b;
        logic [7:0]                      selftest_result;
        aop_pkg::aop_bist_e              bist;
        logic [CNT_W-1:0]                cnt;
        logic [15:0]                     crc;
        aop_pkg::aop_sample_s [LATENCY-1:0] pipe_a;
        aop_pkg::aop_sample_s [LATENCY-1:0] pipe_b;
        aop_pkg::aop_chan_out_s          out_a;
        aop_pkg::aop_chan_out_s          out_b;
        logic [7:0]                      rdata;
    } aop_state_s;

    aop_state_s s_r;
    aop_state_s s_nxt;

    logic                samp;
    logic                pd_pin;
    logic                oeb_pin;
    logic                strap_mode;
    logic                pd_any;
    logic                pnl_rst;
    logic                pns_rst;
    logic                sequence_initialise_bit;
    logic                bist_step;
    logic [aop_pkg::PNL_W-1:0] pnl_q;
    logic [aop_pkg::PNS_W-1:0] pns_q;
    logic [aop_pkg::BPN_W-1:0] bpn_q;

    // Synchronised pins: 0 pd, 1 disable, 2 format strap, 3 select
    assign pd_pin     = s_r.sync2[0];
    assign oeb_pin    = s_r.sync2[1];
    assign strap_mode = s_r.sync2[3];
    assign samp       = s_r.phase;

    // Power state
    assign pd_any = pd_pin | (s_r.power_mode[1:0] != aop_pkg::PWR_NORMAL);
    assign core_power_out   = ~pd_any;
    assign reference_on_out = ~pd_any | (s_r.power_mode[1:0] == aop_pkg::PWR_STBY);

    // Register-bus pulses for the generators
    assign pnl_rst = reg_req_in.wr & ~strap_mode
                   & (reg_req_in.addr == aop_pkg::ADDR_TEST)
                   & reg_req_in.wdata[aop_pkg::TM_PNL_RST];
    assign pns_rst = reg_req_in.wr & ~strap_mode
                   & (reg_req_in.addr == aop_pkg::ADDR_TEST)
                   & reg_req_in.wdata[aop_pkg::TM_PNS_RST];
    assign sequence_initialise_bit = reg_req_in.wr & ~strap_mode
                     & (reg_req_in.addr == aop_pkg::ADDR_BIST)
                     & reg_req_in.wdata[aop_pkg::ST_EN]
                     & reg_req_in.wdata[aop_pkg::ST_INIT]
                     & (s_r.bist == aop_pkg::BIST_IDLE);
    assign bist_step = samp & (s_r.bist == aop_pkg::BIST_RUN);

    // Pattern generators, stepped once per sample
    aop_lfsr #(
        .W    (aop_pkg::PNL_W),
        .TAPS (aop_pkg::PNL_TAPS),
        .SEED (aop_pkg::PNL_SEED)
    ) u_pnl (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .ce_in     (ce_in),
        .init_in   (pnl_rst),
        .step_in   (samp),
        .state_out (pnl_q)
    );

    aop_lfsr #(
        .W    (aop_pkg::PNS_W),
        .TAPS (aop_pkg::PNS_TAPS),
        .SEED (aop_pkg::PNS_SEED)
    ) u_pns (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .ce_in     (ce_in),
        .init_in   (pns_rst),
        .step_in   (samp),
        .state_out (pns_q)
    );

    // Self-test source
    aop_lfsr #(
        .W    (aop_pkg::BPN_W),
        .TAPS (aop_pkg::BPN_TAPS),
        .SEED (aop_pkg::BPN_SEED)
    ) u_bpn (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .ce_in     (ce_in),
        .init_in   (sequence_initialise_bit),
        .step_in   (bist_step),
        .state_out (bpn_q)
    );

    // Encode a sample; raw patterns bypass formatting
    function automatic aop_pkg::aop_chan_out_s fmt_word(
        input aop_pkg::aop_sample_s smp,
        input logic [1:0]           sel,
        input logic                 data_clock_out
    );
        aop_pkg::aop_chan_out_s w;
        w.data_clock_out  = data_clock_out;
        w.ovr  = smp.ovr;
        w.data = smp.code;
        if (!smp.raw) begin
            case (sel)
                aop_pkg::FMT_TWOS: begin
                    w.data = {~smp.code[DW-1], smp.code[DW-2:0]};
                end
                aop_pkg::FMT_GRAY: begin
                    w.data = smp.code ^ (smp.code >> 1);
                end
                default: begin
                    w.data = smp.code;
                end
            endcase
        end
        return w;
    endfunction

    // Choose the source of one channel
    function automatic aop_pkg::aop_sample_s pick(
        input aop_pkg::aop_core_s core,
        input logic [3:0]         tm,
        input logic               alt,
        input logic [DW-1:0]      pnl,
        input logic [DW-1:0]      pns
    );
        aop_pkg::aop_sample_s p;
        p = {1'b0, core};
        case (tm)
            aop_pkg::TP_OFF:    p = {1'b0, core};
            aop_pkg::TP_MID:    p = {2'b00, aop_pkg::CODE_MID};
            aop_pkg::TP_PFS:    p = {2'b00, aop_pkg::CODE_PFS};
            aop_pkg::TP_NFS:    p = {2'b00, aop_pkg::CODE_NFS};
            aop_pkg::TP_CHECK:  p = {2'b10, alt ? aop_pkg::CODE_CHK
                                                : ~aop_pkg::CODE_CHK};
            aop_pkg::TP_PNL:    p = {2'b10, pnl};
            aop_pkg::TP_PNS:    p = {2'b10, pns};
            aop_pkg::TP_TOGGLE: p = {2'b10, alt ? aop_pkg::CODE_PFS
                                                : aop_pkg::CODE_NFS};
            default:            p = {1'b0, core};
        endcase
        return p;
    endfunction

    // One signature step over both output words
    function automatic logic [15:0] crc_step(
        input logic [15:0] crc,
        input logic [21:0] d
    );
        logic [15:0] c;
        c = crc;
        for (int i = 21; i >= 0; i--) begin
            if (c[15] ^ d[i]) begin
                c = {c[14:0], 1'b0} ^ aop_pkg::CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction

    localparam logic [1:0] RST2 = 2'h0;

    // Next-state logic, frozen while clock enable is low
    always_comb begin
        logic [1:0]           fmt_a;
        logic [1:0]           fmt_b;
        logic                 inv_a;
        logic                 inv_b;
        aop_pkg::aop_sample_s in_a;
        aop_pkg::aop_sample_s in_b;
        fmt_a = RST2;
        fmt_b = RST2;
        inv_a = s_r.output_mode_a[aop_pkg::OM_DCO_INV];
        inv_b = s_r.output_mode_b[aop_pkg::OM_DCO_INV];
        in_a  = '0;
        in_b  = '0;
        s_nxt = s_r;
        if (ce_in) begin
            s_nxt.sync1 = {serial_select_pin_in, format_strap_pin_in,
                           output_disable_pin_in, power_down_pin_in};
            s_nxt.sync2 = s_r.sync1;
            s_nxt.phase = ~s_r.phase;
            // Strap caught once, after the synchroniser settles
            if (s_r.strap_cnt != 2'(aop_pkg::STRAP_WAIT)) begin
                s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
                s_nxt.strap_twos = s_r.sync2[2];
            end

            // Self-test sequencer
            case (s_r.bist)
                aop_pkg::BIST_IDLE: begin
                    s_nxt.cnt = '0;
                    s_nxt.crc = aop_pkg::CRC_INIT;
                end
                aop_pkg::BIST_RUN: begin
                    if (samp) begin
                        s_nxt.crc = crc_step(s_r.crc, {s_r.out_a[DW:0],
                                             s_r.out_b[DW:0]});
                        s_nxt.cnt = s_r.cnt + CNT_W'(1);
                        if (s_r.cnt == CNT_W'(BIST_CYCLES - 1)) begin
                            s_nxt.bist = aop_pkg::BIST_CHECK;
                        end
                    end
                end
                aop_pkg::BIST_CHECK: begin
                    s_nxt.selftest_result[aop_pkg::RES_PASS] =
                        (s_r.crc == BIST_SIG);
                    s_nxt.selftest_control[aop_pkg::ST_EN] = 1'b0;
                    s_nxt.bist = aop_pkg::BIST_IDLE;
                end
                default: begin
                    s_nxt.bist = aop_pkg::BIST_IDLE;
                end
            endcase

            // Register writes; ignored while strapped, and win over clears
            if (reg_req_in.wr && !strap_mode) begin
                case (reg_req_in.addr)
                    aop_pkg::ADDR_CHAN_SEL: s_nxt.chan_sel = reg_req_in.wdata;
                    aop_pkg::ADDR_POWER: begin
                        s_nxt.power_mode = reg_req_in.wdata & aop_pkg::PWR_KEEP;
                    end
                    aop_pkg::ADDR_TEST: begin
                        s_nxt.output_test_mode = reg_req_in.wdata
                                               & aop_pkg::TM_KEEP;
                    end
                    aop_pkg::ADDR_BIST: begin
                        s_nxt.selftest_control = reg_req_in.wdata;
                        if (!reg_req_in.wdata[aop_pkg::ST_EN]) begin
                            s_nxt.bist = aop_pkg::BIST_IDLE;
                        end else if (s_r.bist == aop_pkg::BIST_IDLE) begin
                            s_nxt.bist = aop_pkg::BIST_RUN;
                        end
                    end
                    aop_pkg::ADDR_OMODE: begin
                        if (s_r.chan_sel[0]) begin
                            s_nxt.output_mode_a = reg_req_in.wdata;
                        end
                        if (s_r.chan_sel[1]) begin
                            s_nxt.output_mode_b = reg_req_in.wdata;
                        end
                    end
                    default: begin
                    end
                endcase
            end

            // Encoding: strap pin or register field
            if (strap_mode) begin
                fmt_a = s_r.strap_twos ? aop_pkg::FMT_TWOS
                                       : aop_pkg::FMT_OFFSET;
                fmt_b = fmt_a;
            end else begin
                fmt_a = s_r.output_mode_a[aop_pkg::OM_FMT_LO +: 2];
                fmt_b = s_r.output_mode_b[aop_pkg::OM_FMT_LO +: 2];
            end

            // Source select: self-test, test pattern or core
            if (s_r.bist == aop_pkg::BIST_RUN) begin
                in_a = {2'b00, bpn_q[DW-1:0]};
                in_b = in_a;
            end else begin
                in_a = pick(core_a_in, s_r.output_test_mode[3:0], s_r.alt,
                            pnl_q[DW-1:0], {pns_q[0], pns_q});
                in_b = pick(core_b_in, s_r.output_test_mode[3:0], s_r.alt,
                            pnl_q[DW-1:0], {pns_q[0], pns_q});
            end

            // Pipeline and output words, once per sample
            if (samp) begin
                s_nxt.alt = ~s_r.alt;
                s_nxt.pipe_a = {s_r.pipe_a[LATENCY-2:0], in_a};
                s_nxt.pipe_b = {s_r.pipe_b[LATENCY-2:0], in_b};
                s_nxt.out_a = fmt_word(s_r.pipe_a[LATENCY-1], fmt_a, inv_a);
                s_nxt.out_b = fmt_word(s_r.pipe_b[LATENCY-1], fmt_b, inv_b);
            end else begin
                // Rising clock mid-word unless inverted
                s_nxt.out_a.data_clock_out = ~inv_a;
                s_nxt.out_b.data_clock_out = ~inv_b;
                if (s_r.output_mode_a[aop_pkg::OM_MUX]) begin
                    s_nxt.out_a.data = s_r.out_b.data;
                    s_nxt.out_a.ovr  = s_r.out_b.ovr;
                end
            end

            // Registered read-back
            case (reg_req_in.addr)
                aop_pkg::ADDR_CHAN_SEL: s_nxt.rdata = s_r.chan_sel;
                aop_pkg::ADDR_POWER:    s_nxt.rdata = s_r.power_mode;
                aop_pkg::ADDR_TEST:     s_nxt.rdata = s_r.output_test_mode;
                aop_pkg::ADDR_BIST:     s_nxt.rdata = s_r.selftest_control;
                aop_pkg::ADDR_OMODE: begin
                    s_nxt.rdata = s_r.chan_sel[0] ? s_r.output_mode_a
                                                  : s_r.output_mode_b;
                end
                aop_pkg::ADDR_BIST_RES: s_nxt.rdata = s_r.selftest_result;
                default:                s_nxt.rdata = aop_pkg::RST_ZERO;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_r          <= '0;
            s_r.chan_sel <= aop_pkg::RST_CHAN_SEL;
            s_r.bist     <= aop_pkg::BIST_IDLE;
            s_r.crc      <= aop_pkg::CRC_INIT;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Drivers float on power-down, disable pin or own disable bit
    assign chan_a_oe_out = ~pd_any & ~oeb_pin
                         & ~s_r.output_mode_a[aop_pkg::OM_DIS];
    assign chan_b_oe_out = ~pd_any & ~oeb_pin
                         & ~s_r.output_mode_b[aop_pkg::OM_DIS];
    assign chan_a_out    = s_r.out_a;
    assign chan_b_out    = s_r.out_b;
    assign reg_rdata_out = s_r.rdata;
    assign bist_busy_out = (s_r.bist != aop_pkg::BIST_IDLE);
endmodule

// *** test/aop_props.sv ***
// Property checker for the converter output path
`timescale 1ns/1ps
module aop_props #(
    parameter int BIST_CYCLES = 512
) (
    input wire logic                   clk_in,
    input wire logic                   rst_b_in,
    input wire logic                   ce_in,
    input wire logic                   power_down_pin_in,
    input wire logic                   output_disable_pin_in,
    input wire aop_pkg::aop_chan_out_s chan_a_out,
    input wire logic                   chan_a_oe_out,
    input wire logic                   chan_b_oe_out,
    input wire logic                   core_power_out,
    input wire logic                   reference_on_out,
    input wire logic                   bist_busy_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    logic [11:0] busy_cnt_r;
    // Length of the current self-test run
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) busy_cnt_r <= 12'h000;
        else busy_cnt_r <= bist_busy_out ? busy_cnt_r + 12'h001 : 12'h000;
    end
    // Output drivers and power state
    pd_float_a: assert property (
        (power_down_pin_in && ce_in)[*4] |-> !chan_a_oe_out && !chan_b_oe_out)
        else $error("outputs driven during power-down pin");
    core_off_a: assert property (
        (power_down_pin_in && ce_in)[*4] |-> !core_power_out)
        else $error("core powered while pin requests power-down");
    oe_pin_a: assert property (
        (output_disable_pin_in && ce_in)[*4] |-> !chan_a_oe_out && !chan_b_oe_out)
        else $error("outputs driven while disable pin high");
    off_float_a: assert property (!core_power_out |->
        !chan_a_oe_out && !chan_b_oe_out)
        else $error("outputs driven with core off");
    ref_on_a: assert property (core_power_out |-> reference_on_out)
        else $error("reference off while running");
    // Data clock, data timing and self-test length
    dco_tog_a: assert property ($past(rst_b_in) && $past(ce_in) |->
        chan_a_out.data_clock_out != $past(chan_a_out.data_clock_out))
        else $error("data clock missed a toggle");
    data_hold_a: assert property ($changed(chan_a_out.data) |=>
        $stable(chan_a_out.data))
        else $error("data word held less than one sample");
    bist_len_a: assert property (busy_cnt_r <= 12'(2*BIST_CYCLES+8))
        else $error("self-test runs too long");
    cover property ($rose(bist_busy_out));
    cover property ($fell(chan_a_oe_out));
    cover property ($rose(chan_a_out.data_clock_out));
endmodule
bind aop_top aop_props #(.BIST_CYCLES(BIST_CYCLES)) u_props (.clk_in,
    .rst_b_in, .ce_in, .power_down_pin_in, .output_disable_pin_in,
    .chan_a_out, .chan_a_oe_out, .chan_b_oe_out, .core_power_out,
    .reference_on_out, .bist_busy_out);

// *** test/aop_capture.sv ***
// Capture register model sampling one output bus on its data clock
`timescale 1ns/1ps
module aop_capture (
    input  wire logic                   clk_in,
    input  wire logic                   rst_b_in,
    input  wire aop_pkg::aop_chan_out_s bus_in,
    input  wire logic                   oe_in,
    output aop_pkg::aop_chan_out_s      word_out
);
    aop_pkg::aop_chan_out_s last_r;
    aop_pkg::aop_chan_out_s pin_w;
    // Floating pins read as the inverse of their last level
    assign pin_w = oe_in ? bus_in : ~last_r;
    // Capture the word on the rising data clock
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            last_r   <= '0;
            word_out <= '0;
        end else begin
            last_r <= pin_w;
            if (pin_w.data_clock_out && !last_r.data_clock_out) word_out <= pin_w;
        end
    end
endmodule

// *** test/aop_top_tb.sv ***
// Self-checking bench for the converter output path
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module aop_top_tb;
    typedef struct packed {
        logic [3:0] tp;
        logic [1:0] fmt;
        logic [9:0] exp;
    } aop_row_s;
    localparam aop_row_s ROWS [9] = '{'{4'h1, 2'h0, 10'h200},
        '{4'h1, 2'h1, 10'h000}, '{4'h1, 2'h2, 10'h300}, '{4'h2, 2'h0, 10'h3FF},
        '{4'h2, 2'h1, 10'h1FF}, '{4'h2, 2'h2, 10'h200}, '{4'h3, 2'h0, 10'h000},
        '{4'h3, 2'h1, 10'h200}, '{4'h3, 2'h2, 10'h000}};
    logic clk_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1, pd = 1'b0, oed = 1'b0;
    logic fmt_pin = 1'b0, sel_pin = 1'b0, oe_a, oe_b, cpwr, refon, busy;
    aop_pkg::aop_core_s     core_a = '0, core_b = '0;
    aop_pkg::aop_reg_req_s  req = '0;
    aop_pkg::aop_chan_out_s ch_a, ch_b, cap_a, cap_b;
    logic [7:0]             r, rdata;
    logic [9:0]             w0;
    int                     n_fail = 0, n_checks = 0, n;
    aop_top #(.BIST_CYCLES(16)) dut_u (.clk_in, .rst_b_in, .ce_in,
        .power_down_pin_in(pd), .output_disable_pin_in(oed),
        .format_strap_pin_in(fmt_pin), .serial_select_pin_in(sel_pin),
        .core_a_in(core_a), .core_b_in(core_b), .reg_req_in(req),
        .reg_rdata_out(rdata), .chan_a_out(ch_a), .chan_b_out(ch_b),
        .chan_a_oe_out(oe_a), .chan_b_oe_out(oe_b), .core_power_out(cpwr),
        .reference_on_out(refon), .bist_busy_out(busy));
    aop_capture cap_a_u (.clk_in, .rst_b_in, .bus_in(ch_a), .oe_in(oe_a),
        .word_out(cap_a));
    aop_capture cap_b_u (.clk_in, .rst_b_in, .bus_in(ch_b), .oe_in(oe_b),
        .word_out(cap_b));
    // Register access, driven from one falling edge to the next
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{1'b1, a, d};
        @(negedge clk_in);
        req.wr = 1'b0;
        @(negedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a);
        req.addr = a;
        @(negedge clk_in);
        r = rdata;
    endtask
    task automatic wait_n(input int c);
        repeat (c) @(negedge clk_in);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Clock and watchdog
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
    // Main sequence
    initial begin
        repeat (16) @(negedge clk_in);
        `CHK({oe_a, oe_b, cpwr, refon, busy}, 5'b11110)
        rst_b_in = 1'b1;
        wait_n(4);
        rd(8'h14); `CHK(r, 8'h00)
        rd(8'h30); `CHK(r, 8'h00)
        foreach (ROWS[i]) begin
            wr(8'h14, {6'h00, ROWS[i].fmt});
            wr(8'h0D, {4'h0, ROWS[i].tp});
            wait_n(30);
            `CHK(cap_a.data, ROWS[i].exp)
            `CHK(cap_b.data, ROWS[i].exp)
        end
        // Pattern restart and frozen sample clock
        wr(8'h0D, 8'h15); wait_n(30); w0 = ch_a.data;
        wr(8'h0D, 8'h15); wait_n(30);
        `CHK(ch_a.data, w0)
        ce_in = 1'b0; wait_n(5);
        `CHK(ch_a.data, w0)
        ce_in = 1'b1; wr(8'h0D, 8'h00); wr(8'h14, 8'h00);
        // Pipeline delay and overrange
        core_a = '{1'b0, 10'h123}; wait_n(30);
        core_a = '{1'b1, 10'h0AB}; n = 0;
        while (ch_a.data !== 10'h0AB && n < 40) begin
            @(negedge clk_in); n++;
        end
        `CHK(n == 19 || n == 20, 1'b1)
        `CHK(ch_a.ovr, 1'b1)
        // Power-down, standby and output disable
        pd = 1'b1; wait_n(4); `CHK({oe_a, oe_b, cpwr}, 3'b000)
        pd = 1'b0; wait_n(4); `CHK({oe_a, oe_b, cpwr}, 3'b111)
        wr(8'h08, 8'h02); wait_n(2); `CHK({oe_a, cpwr, refon}, 3'b001)
        wr(8'h08, 8'h01); wait_n(2); `CHK({oe_b, cpwr, refon}, 3'b000)
        wr(8'h08, 8'h00); oed = 1'b1; wait_n(4);
        `CHK({oe_a, oe_b}, 2'b00)
        oed = 1'b0; wr(8'h05, 8'h01); wr(8'h14, 8'h10); wait_n(2);
        `CHK({oe_a, oe_b}, 2'b01)
        wr(8'h14, 8'h00); wr(8'h05, 8'h03);
        // Self-test run
        wr(8'h0E, 8'h05); `CHK({busy, oe_a, oe_b}, 3'b111)
        n = 0;
        while (busy === 1'b1 && n < 100) begin
            @(negedge clk_in); n++;
        end
        `CHK(n >= 30 && n <= 36, 1'b1)
        rd(8'h0E); `CHK(r[0], 1'b0)
        rd(8'h24); `CHK(r[0], 1'b0)
        // Strap mode with serial select held high
        rst_b_in = 1'b0; sel_pin = 1'b1; fmt_pin = 1'b1;
        core_a = '{1'b0, 10'h200}; wait_n(2); rst_b_in = 1'b1;
        wait_n(3); wr(8'h0D, 8'h02); wait_n(30);
        `CHK(ch_a.data, 10'h000)
        stop_test();
    end
endmodule
